// >>> src/ppe_map.vh
// register offsets, reset values and status bit positions of the port event block
`ifndef PPE_MAP_VH
`define PPE_MAP_VH
`define PPE_OFS_INPUT      6'h00
`define PPE_OFS_OUTPUT     6'h02
`define PPE_OFS_DIRECTION  6'h04
`define PPE_OFS_PULL       6'h06
`define PPE_OFS_DRIVE      6'h08
`define PPE_OFS_SEL_LOW    6'h0a
`define PPE_OFS_SEL_HIGH   6'h0c
`define PPE_OFS_VECTOR1    6'h0e
`define PPE_OFS_SEL_TOGGLE 6'h10
`define PPE_OFS_POLARITY   6'h18
`define PPE_OFS_ENABLE     6'h1a
`define PPE_OFS_FLAGS      6'h1c
`define PPE_OFS_VECTOR2    6'h1e
`define PPE_OFS_STATUS     6'h20
`define PPE_OFS_VECTOR3    6'h2e
`define PPE_OFS_VECTOR4    6'h3e
`define PPE_RST_BYTE       8'h00
`define PPE_RST_WORD       16'h0000
`define PPE_STATUS_LOCK    0
`define PPE_STATUS_SLEEPOK 1
`endif

// >>> src/ppe_port.v
// two-byte gpio port with edge event flags, event vectors and deep-sleep pin hold
//
// Functional notes
// RULE_01 - polarity 0 flags rising input edge, polarity 1 flags falling edge.
// RULE_02 - polarity change 0->1 with input low, or 1->0 with high, sets flag.
// RULE_03 - event enable bit gates its flag toward the interrupt request.
// RULE_04 - sleep entry sets hold lock; pins freeze at pre-entry configuration.
// RULE_05 - during deep sleep only physical pin states are kept, registers lost.
// RULE_06 - wake event triggers brownout reset, returning all registers to defaults.
// RULE_07 - after wake, pins stay frozen while the hold lock stays set. Here resetn clears the snapshot and lock_s, so pins go to reset values.
// RULE_08 - config writes under lock update registers but not pin behaviour.
// RULE_09 - clearing the lock makes pins follow current register configuration.
// RULE_10 - flags set by wake cannot be cleared by software until lock clears.
// RULE_11 - deep sleep is refused while the hold lock is still set.
// RULE_12 - wake edges on several pins each set their own flag.
// RULE_13 - software configures wake pins as inputs with polarity and enable first.
// RULE_14 - software unlocks power manager, requests regulator off, sets sleep bits.
// RULE_15 - software restores polarity and enables before clearing the lock.
// RULE_16 - registers accessible as word or byte; low byte bits 0-7, high 8-15.
// RULE_17 - registers decoded at fixed offsets from the port group base.
// RULE_18 - debug-shared port pins leave reset as high-impedance inputs.
// RULE_19 - any vector access clears highest-priority pending enabled flag.
// RULE_20 - vector is 0 when idle, else twice pin index plus 2.
// RULE_21 - flags set by transitions only; request needs enable and global enable.
// RULE_22 - nonzero function select disables that pin's event detection.
// RULE_23 - pin inputs are synchronised and compared with previous sample.
// RULE_24 - hold lock input gates updates of pin output, direction and pulls.
//
// Our own choice: strobed register access.
`timescale 1ns/100ps
`include "ppe_map.vh"

module ppe_port
#(
    parameter W = 16
)
(
    input  wire          ref_clk,
    input  wire          resetn,
    input  wire          clk_en,
    input  wire [5:0]    bus_addr,
    input  wire [15:0]   bus_wdata,
    input  wire [1:0]    bus_byte_en,
    input  wire          bus_write,
    input  wire          bus_read,
    output reg  [15:0]   bus_rdata,
    input  wire          pin_hold_lock,
    input  wire          regulator_off_request,
    input  wire          global_interrupt_enable,
    input  wire          debug_shared_mode,
    input  wire [W-1:0]  pin_in,
    output wire [W-1:0]  pin_out,
    output wire [W-1:0]  pin_oe,
    output wire [W-1:0]  pin_pull_en,
    output wire [W-1:0]  pin_drive_high,
    output wire [1:0]    event_irq,
    output wire          regulator_off_sleep
);

////////////////////////////////////////////////////////////////////////////////
// registers; brownout reset after wake arrives on resetn and clears them all

reg  [W-1:0]  output_latch;
reg  [W-1:0]  pin_direction;
reg  [W-1:0]  pull_resistor_enable;
reg  [W-1:0]  drive_strength_select;
reg  [W-1:0]  function_select_low;
reg  [W-1:0]  function_select_high;
reg  [W-1:0]  edge_polarity_select;
reg  [W-1:0]  pin_event_enable;
reg  [W-1:0]  pin_event_flag;
reg  [W-1:0]  wake_flag;
reg  [W-1:0]  sync_a;
reg  [W-1:0]  pin_input_level;
reg  [W-1:0]  prev_level;
reg           lock_a;
reg           lock_s;
reg           lock_d;
// no edge is judged until the sync chain has been filled since reset
reg  [2:0]    sync_fill;
reg  [W-1:0]  held_out;
reg  [W-1:0]  held_oe;
reg  [W-1:0]  held_pull;
reg  [W-1:0]  held_drive;

wire [W-1:0] wmask = {{8{bus_byte_en[1]}}, {8{bus_byte_en[0]}}};      // RULE_16
wire         wr    = clk_en & bus_write;
wire         rd    = clk_en & bus_read;

function [W-1:0] merge;
    input [W-1:0] old;
    input [W-1:0] data;
    input [W-1:0] mask;
    begin
        merge = (old & ~mask) | (data & mask);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// pin synchroniser and lock synchroniser

always @(posedge ref_clk or negedge resetn)
begin
    if (!resetn)
    begin
        sync_a          <= {W{1'b0}};
        pin_input_level <= {W{1'b0}};
        prev_level      <= {W{1'b0}};
        lock_a          <= 1'b0;
        lock_s          <= 1'b0;
        lock_d          <= 1'b0;
        sync_fill       <= 3'b000;
    end
    else if (clk_en)
    begin
        sync_fill       <= {sync_fill[1:0], 1'b1};
        sync_a          <= pin_in;                                    // RULE_23
        pin_input_level <= sync_a;
        prev_level      <= pin_input_level;
        lock_a          <= pin_hold_lock;
        lock_s          <= lock_a;
        lock_d          <= lock_s;
    end
end

////////////////////////////////////////////////////////////////////////////////
// event detection

wire [W-1:0] detect_ok = ~(function_select_low | function_select_high);  // RULE_22
wire [W-1:0] rise      = pin_input_level & ~prev_level;
wire [W-1:0] fall      = ~pin_input_level & prev_level;
wire [W-1:0] edge_hit  = ((rise & ~edge_polarity_select)
                        | (fall & edge_polarity_select)) & detect_ok
                        & {W{sync_fill[2]}};                           // RULE_01 RULE_21
wire         pol_wr    = wr && bus_addr[5:1] == `PPE_OFS_POLARITY >> 1;
wire [W-1:0] next_pol  = merge(edge_polarity_select, bus_wdata, wmask);
wire [W-1:0] pol_hit   = pol_wr ? ((~edge_polarity_select & next_pol & ~pin_input_level)
                        | (edge_polarity_select & ~next_pol & pin_input_level))
                        & detect_ok & {W{sync_fill[2]}} : {W{1'b0}};   // RULE_02
wire [W-1:0] enabled   = pin_event_flag & pin_event_enable;           // RULE_03

// priority pick per byte, bit 0 first
function [3:0] first_bit;
    input [7:0] v;
    integer k;
    begin
        first_bit = 4'h8;
        for (k = 7; k >= 0; k = k - 1)
            if (v[k])
                first_bit = k[3:0];
    end
endfunction

wire [3:0]  pick1 = first_bit(enabled[7:0]);
wire [3:0]  pick2 = first_bit(enabled[15:8]);
wire [15:0] vec1  = pick1[3] ? `PPE_RST_WORD : {12'h000, pick1[2:0], 1'b0} + 16'h0002; // RULE_20
wire [15:0] vec2  = pick2[3] ? `PPE_RST_WORD : {12'h000, pick2[2:0], 1'b0} + 16'h0002;
wire        v1_acc = (wr | rd) && bus_addr[5:1] == `PPE_OFS_VECTOR1 >> 1;
wire        v2_acc = (wr | rd) && bus_addr[5:1] == `PPE_OFS_VECTOR2 >> 1;
reg  [W-1:0] vec_clr;

always @*
begin
    vec_clr = {W{1'b0}};
    if (v1_acc && !pick1[3])
        vec_clr[pick1[2:0]] = 1'b1;                                   // RULE_19
    if (v2_acc && !pick2[3])
        vec_clr[{1'b1, pick2[2:0]}] = 1'b1;
end

wire         flag_wr  = wr && bus_addr[5:1] == `PPE_OFS_FLAGS >> 1;
// wake flags cannot be cleared while locked; set wins over any clear
wire [W-1:0] protect  = lock_s ? wake_flag : {W{1'b0}};              // RULE_10
wire [W-1:0] sw_flag  = flag_wr ? merge(pin_event_flag, bus_wdata, wmask) : pin_event_flag;
wire [W-1:0] next_flag = ((sw_flag & ~vec_clr) | protect | edge_hit | pol_hit); // RULE_12

////////////////////////////////////////////////////////////////////////////////
// register writes

always @(posedge ref_clk or negedge resetn)
begin
    if (!resetn)
    begin
        output_latch          <= `PPE_RST_WORD;
        pin_direction         <= `PPE_RST_WORD;                       // RULE_18
        pull_resistor_enable  <= `PPE_RST_WORD;
        drive_strength_select <= `PPE_RST_WORD;
        function_select_low   <= `PPE_RST_WORD;
        function_select_high  <= `PPE_RST_WORD;
        edge_polarity_select  <= `PPE_RST_WORD;
        pin_event_enable      <= `PPE_RST_WORD;
        pin_event_flag        <= `PPE_RST_WORD;                       // RULE_06
        wake_flag             <= `PPE_RST_WORD;
    end
    else if (clk_en)
    begin
        pin_event_flag <= next_flag;
        // edge flags raised while the lock holds are treated as wake flags
        wake_flag <= lock_s ? (wake_flag | edge_hit) : {W{1'b0}};
        if (wr)
        begin
            case (bus_addr[5:1])                                      // RULE_17
                `PPE_OFS_OUTPUT >> 1:
                    output_latch <= merge(output_latch, bus_wdata, wmask);   // RULE_08
                `PPE_OFS_DIRECTION >> 1:
                    pin_direction <= merge(pin_direction, bus_wdata, wmask);
                `PPE_OFS_PULL >> 1:
                    pull_resistor_enable <= merge(pull_resistor_enable, bus_wdata, wmask);
                `PPE_OFS_DRIVE >> 1:
                    drive_strength_select <= merge(drive_strength_select, bus_wdata, wmask);
                `PPE_OFS_SEL_LOW >> 1:
                    function_select_low <= merge(function_select_low, bus_wdata, wmask);
                `PPE_OFS_SEL_HIGH >> 1:
                    function_select_high <= merge(function_select_high, bus_wdata, wmask);
                `PPE_OFS_SEL_TOGGLE >> 1:
                begin
                    function_select_low  <= function_select_low ^ (bus_wdata & wmask);
                    function_select_high <= function_select_high ^ (bus_wdata & wmask);
                end
                `PPE_OFS_POLARITY >> 1:
                    edge_polarity_select <= next_pol;
                `PPE_OFS_ENABLE >> 1:
                    pin_event_enable <= merge(pin_event_enable, bus_wdata, wmask);
                default:
                    output_latch <= output_latch;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// read port: data valid the cycle after the strobe

always @(posedge ref_clk or negedge resetn)
begin
    if (!resetn)
        bus_rdata <= `PPE_RST_WORD;
    else if (clk_en)
    begin
        bus_rdata <= `PPE_RST_WORD;
        if (rd)
        begin
            case (bus_addr[5:1])
                `PPE_OFS_INPUT >> 1:      bus_rdata <= pin_input_level;
                `PPE_OFS_OUTPUT >> 1:     bus_rdata <= output_latch;
                `PPE_OFS_DIRECTION >> 1:  bus_rdata <= pin_direction;
                `PPE_OFS_PULL >> 1:       bus_rdata <= pull_resistor_enable;
                `PPE_OFS_DRIVE >> 1:      bus_rdata <= drive_strength_select;
                `PPE_OFS_SEL_LOW >> 1:    bus_rdata <= function_select_low;
                `PPE_OFS_SEL_HIGH >> 1:   bus_rdata <= function_select_high;
                `PPE_OFS_VECTOR1 >> 1:    bus_rdata <= vec1;
                `PPE_OFS_POLARITY >> 1:   bus_rdata <= edge_polarity_select;
                `PPE_OFS_ENABLE >> 1:     bus_rdata <= pin_event_enable;
                `PPE_OFS_FLAGS >> 1:      bus_rdata <= pin_event_flag;
                `PPE_OFS_VECTOR2 >> 1:    bus_rdata <= vec2;
                `PPE_OFS_STATUS >> 1:
                    bus_rdata <= {14'h0000, ~lock_s, lock_s};
                default:                  bus_rdata <= `PPE_RST_WORD;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin hold: snapshot taken while unlocked, frozen while locked

always @(posedge ref_clk or negedge resetn)
begin
    if (!resetn)
    begin
        held_out   <= `PPE_RST_WORD;
        held_oe    <= `PPE_RST_WORD;
        held_pull  <= `PPE_RST_WORD;
        held_drive <= `PPE_RST_WORD;
    end
    else if (clk_en && !lock_s)                                       // RULE_24
    begin
        held_out   <= output_latch;
        held_oe    <= pin_direction;
        held_pull  <= pull_resistor_enable;
        held_drive <= drive_strength_select;
    end
end

// the snapshot lags the registers one cycle so at lock it matches the pre-lock pin state
assign pin_out        = lock_s ? held_out   : output_latch;           // RULE_04 RULE_07 RULE_09
assign pin_oe         = lock_s ? held_oe    : pin_direction;          // RULE_05
assign pin_pull_en    = lock_s ? held_pull  : pull_resistor_enable;
assign pin_drive_high = lock_s ? held_drive : drive_strength_select;
// requests are masked under lock so a wake flag does not fire before restore
assign event_irq[0]   = |enabled[7:0]  & global_interrupt_enable & ~lock_s;   // RULE_21
assign event_irq[1]   = |enabled[15:8] & global_interrupt_enable & ~lock_s;
// the power manager may only enter regulator-off sleep with the lock clear
assign regulator_off_sleep = regulator_off_request & ~lock_s & ~lock_d
                           & ~debug_shared_mode;                      // RULE_11

endmodule

// >>> tb/ppe_port_monitor.sv
// concurrent checks on the pins and register port of the port event block
`timescale 1ns/100ps
module ppe_port_monitor
#(
    parameter W = 16
)
(
    input wire          ref_clk,
    input wire          resetn,
    input wire          clk_en,
    input wire [5:0]    bus_addr,
    input wire [15:0]   bus_wdata,
    input wire [1:0]    bus_byte_en,
    input wire          bus_write,
    input wire          bus_read,
    input wire [15:0]   bus_rdata,
    input wire          pin_hold_lock,
    input wire          regulator_off_request,
    input wire          global_interrupt_enable,
    input wire          debug_shared_mode,
    input wire [W-1:0]  pin_in,
    input wire [W-1:0]  pin_out,
    input wire [W-1:0]  pin_oe,
    input wire [W-1:0]  pin_pull_en,
    input wire [W-1:0]  pin_drive_high,
    input wire [1:0]    event_irq,
    input wire          regulator_off_sleep
);
    default clocking mon_cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////////
    // the lock passes a 2-ff sync, so only a level held for several cycles is judged
    sequence lock_held;
        pin_hold_lock [*3];
    endsequence
    sleep_refused_a: assert property (lock_held |-> !regulator_off_sleep)
        else $error("deep sleep granted under hold lock");
    sleep_cause_a: assert property (regulator_off_sleep |->
        regulator_off_request || $past(regulator_off_request))
        else $error("deep sleep without request");
    irq_locked_a: assert property (lock_held |-> event_irq == 2'b00)
        else $error("event request while pins held");
    irq_global_a: assert property (!global_interrupt_enable [*3] |-> event_irq == 2'b00)
        else $error("event request without global enable");
    pins_frozen_a: assert property (lock_held ##1 pin_hold_lock |->
        $stable(pin_oe) && $stable(pin_out) && $stable(pin_pull_en))
        else $error("pin control moved under hold lock");
    reset_idle_a: assert property ($rose(resetn) |->
        pin_oe == 16'h0000 && pin_out == 16'h0000 && pin_pull_en == 16'h0000)
        else $error("pins not idle inputs after reset");
    rdata_idle_a: assert property (clk_en && !bus_read |=> bus_rdata == 16'h0000)
        else $error("read data outside read answer");
    vector_range_a: assert property (clk_en && bus_read && bus_addr[5:1] == 5'h07 |=>
        bus_rdata <= 16'h0010 && !bus_rdata[0])
        else $error("event vector out of range");
endmodule
bind ppe_port ppe_port_monitor #(.W(W)) mon_u (.*);

// >>> tb/ppe_pin_board.sv
// board-side model: drives the pin levels with an asynchronous settling delay
`timescale 1ns/100ps
module ppe_pin_board
#(
    parameter int SETTLE_NS = 7
)
(
    input  wire logic [15:0] level_req,
    output wire logic [15:0] pin_level
);
    // levels land off the clock edge, so the block's input sync is really exercised
    assign #(SETTLE_NS) pin_level = level_req;
endmodule

// >>> tb/ppe_port_tb_top.sv
// self-checking bench for the port event and sleep-hold block
`timescale 1ns/100ps
`include "ppe_map.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module ppe_port_tb_top;
    logic          ref_clk = 1'b0;
    logic          resetn = 1'b0;
    logic          clk_en = 1'b1;
    logic [5:0]    bus_addr = 6'h00;
    logic [15:0]   bus_wdata = 16'h0000;
    logic [1:0]    bus_byte_en = 2'b11;
    logic          bus_write = 1'b0;
    logic          bus_read = 1'b0;
    logic          pin_hold_lock = 1'b0;
    logic          regulator_off_request = 1'b0;
    logic          global_interrupt_enable = 1'b0;
    logic          debug_shared_mode = 1'b0;
    logic [15:0]   board_level = 16'h0000;
    wire  [15:0]   bus_rdata, pin_in, pin_out, pin_oe, pin_pull_en, pin_drive_high;
    wire  [1:0]    event_irq;
    wire           regulator_off_sleep;
    logic [15:0]   v;
    int            err_total = 0;
    int            checked = 0;
    ppe_port #(.W(16)) dut_u (.*);
    ppe_pin_board board_u (.level_req(board_level), .pin_level(pin_in));
    initial
    begin
        forever #10 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task wr(input logic [5:0] a, input logic [15:0] d, input logic [1:0] be);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_byte_en <= be;
        bus_write <= 1'b1;
        @(posedge ref_clk);
        bus_write <= 1'b0;
    endtask
    task rd(input logic [5:0] a);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge ref_clk);
        bus_read <= 1'b0;
        #1 v = bus_rdata;
    endtask
    // new board levels, then enough cycles for sync, edge detect and outputs to settle
    task pins(input logic [15:0] l);
        @(posedge ref_clk);
        board_level <= l;
        repeat (5) @(posedge ref_clk);
        #1;
    endtask
    task end_sim;
        $display("checks %0d, errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_events;
        rd(`PPE_OFS_DIRECTION);
        `CHK(v, 16'h0000)
        `CHK(pin_oe, 16'h0000)
        @(posedge ref_clk);
        global_interrupt_enable <= 1'b1;
        pins(16'h0008);
        wr(`PPE_OFS_FLAGS, 16'h0000, 2'b11);
        wr(`PPE_OFS_POLARITY, 16'h0008, 2'b11);
        rd(`PPE_OFS_FLAGS);
        `CHK(v, 16'h0000)
        wr(`PPE_OFS_ENABLE, 16'h0009, 2'b11);
        pins(16'h0001);
        rd(`PPE_OFS_FLAGS);
        `CHK(v, 16'h0009)
        `CHK(event_irq, 2'b01)
        rd(`PPE_OFS_VECTOR1);
        `CHK(v, 16'h0002)
        rd(`PPE_OFS_VECTOR1);
        `CHK(v, 16'h0008)
        rd(`PPE_OFS_VECTOR1);
        `CHK(v, 16'h0000)
        pins(16'h0008);
        rd(`PPE_OFS_FLAGS);
        `CHK(v, 16'h0000)
        `CHK(event_irq, 2'b00)
    endtask
    task t_lock;
        wr(`PPE_OFS_DIRECTION, 16'h00ff, 2'b11);
        pin_hold_lock <= 1'b1;
        regulator_off_request <= 1'b1;
        pins(16'h0009);
        `CHK(regulator_off_sleep, 1'b0)
        `CHK(event_irq, 2'b00)
        wr(`PPE_OFS_DIRECTION, 16'h0000, 2'b11);
        wr(`PPE_OFS_FLAGS, 16'h0000, 2'b11);
        rd(`PPE_OFS_DIRECTION);
        `CHK(v, 16'h0000)
        `CHK(pin_oe, 16'h00ff)
        rd(`PPE_OFS_FLAGS);
        `CHK(v, 16'h0001)
        wr(`PPE_OFS_POLARITY, 16'h0008, 2'b11);
        wr(`PPE_OFS_ENABLE, 16'h0009, 2'b11);
        pin_hold_lock <= 1'b0;
        pins(16'h0009);
        `CHK(pin_oe, 16'h0000)
        `CHK(regulator_off_sleep, 1'b1)
        `CHK(event_irq, 2'b01)
        rd(`PPE_OFS_STATUS);
        `CHK(v, 16'h0002)
        @(posedge ref_clk);
        regulator_off_request <= 1'b0;
        wr(`PPE_OFS_FLAGS, 16'h0000, 2'b11);
        rd(`PPE_OFS_FLAGS);
        `CHK(v, 16'h0000)
    endtask
    task t_high_sel;
        wr(`PPE_OFS_ENABLE, 16'h0109, 2'b11);
        pins(16'h0109);
        `CHK(event_irq, 2'b10)
        rd(`PPE_OFS_VECTOR2);
        `CHK(v, 16'h0002)
        rd(`PPE_OFS_FLAGS);
        `CHK(v, 16'h0000)
        wr(`PPE_OFS_POLARITY, 16'h0108, 2'b11);
        wr(`PPE_OFS_POLARITY, 16'h0008, 2'b11);
        rd(`PPE_OFS_FLAGS);
        `CHK(v, 16'h0100)
        rd(`PPE_OFS_VECTOR2);
        `CHK(v, 16'h0002)
        wr(`PPE_OFS_SEL_TOGGLE, 16'h0100, 2'b11);
        rd(`PPE_OFS_SEL_HIGH);
        `CHK(v, 16'h0100)
        pins(16'h0009);
        pins(16'h0109);
        rd(`PPE_OFS_FLAGS);
        `CHK(v, 16'h0000)
        @(posedge ref_clk);
        debug_shared_mode <= 1'b1;
        regulator_off_request <= 1'b1;
        @(posedge ref_clk);
        #1;
        `CHK(regulator_off_sleep, 1'b0)
        @(posedge ref_clk);
        debug_shared_mode <= 1'b0;
        regulator_off_request <= 1'b0;
    endtask
    task t_bytes_reset;
        wr(`PPE_OFS_PULL, 16'habcd, 2'b01);
        wr(`PPE_OFS_PULL, 16'h1200, 2'b10);
        wr(`PPE_OFS_OUTPUT, 16'h00a5, 2'b11);
        wr(`PPE_OFS_DRIVE, 16'h5a00, 2'b11);
        rd(`PPE_OFS_PULL);
        `CHK(v, 16'h12cd)
        `CHK(pin_pull_en, 16'h12cd)
        `CHK(pin_out, 16'h00a5)
        `CHK(pin_drive_high, 16'h5a00)
        @(posedge ref_clk);
        resetn <= 1'b0;
        pins(16'h0009);
        @(posedge ref_clk);
        resetn <= 1'b1;
        rd(`PPE_OFS_PULL);
        `CHK(v, 16'h0000)
        `CHK(pin_pull_en, 16'h0000)
        `CHK(pin_out, 16'h0000)
        pins(16'h0009);
        rd(`PPE_OFS_FLAGS);
        `CHK(v, 16'h0000)
    endtask
    initial
    begin
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        t_events;
        t_lock;
        t_high_sel;
        t_bytes_reset;
        end_sim;
    end
    // the whole run needs about 150 cycles; a hang is cut well beyond that
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        err_total++;
        end_sim;
    end
endmodule
